/* File: pkg/poll_regs_pkg.sv */
`default_nettype none

package poll_regs_pkg;

  // Register port addresses, one per register index
  localparam logic [7:0] ADDR_NEXT_RX = 8'h2C;
  localparam logic [7:0] ADDR_POLL = 8'h2E;
  localparam logic [7:0] ADDR_INTERVAL = 8'h2F;
  localparam logic [7:0] ADDR_SCRATCH_ZERO = 8'h30;
  localparam logic [7:0] ADDR_SCRATCH_ONE = 8'h32;
  localparam logic [7:0] ADDR_SCRATCH_TWO = 8'h34;

  // Field positions of the next-receive shadow word and of the descriptor word one status byte
  localparam int STATUS_LSB = 24;
  localparam int STATUS_MSB = 31;
  localparam int COUNT_LSB = 0;
  localparam int COUNT_MSB = 11;
  localparam int DESC_STATUS_LSB = 8;
  localparam int DESC_STATUS_MSB = 15;

  // Interval register fields
  localparam int INTERVAL_USED_LSB = 4;
  localparam int INTERVAL_MSB = 15;
  localparam logic [15:0] INTERVAL_DEFAULT = 16'h0000;
  localparam logic [3:0] INTERVAL_IGNORED_BITS = 4'h0;

  // Reset values
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [11:0] COUNT_RESET = 12'h000;
  localparam logic [16:0] POLL_RESET = 17'h1_0000;

  // One clock period is two half-period units of the interval
  localparam int CRYSTAL_PERIOD_NS = 25;
  localparam int HALF_PERIOD_NS = CRYSTAL_PERIOD_NS / 2;
  localparam logic [17:0] HALF_UNITS_PER_CYCLE = 18'h0_0002;

  typedef struct packed {
    logic [7:0] status;
    logic [11:0] count;
  } rx_shadow_type;

  typedef enum logic [1:0] {
    SEQ_STOPPED = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_RUNNING = 2'b10,
    SEQ_SUSPENDED = 2'b11
  } seq_state_type;

endpackage

`default_nettype wire

/* File: hdl/descriptor_poll_state_regs.sv */
// Operation
// - Shadow bits 31-24 copy descriptor word one status bits 15:8.
// - Shadow bits 23-12 reserved; writes dropped, reads give zero.
// - Shadow bits 11-0 copy byte count of descriptor word two.
// - Registers reachable only while halt or suspend bit is set.
// - Sixteen-bit poll counter advances with time under the sequencer.
// - Poll counter wrap is what triggers each ring poll.
// - Initialization loads zero interval; a halted write overrides it.
// - Interval is two's complement, half-period units, low four bits ignored.
// - Zero interval gives 32768 crystal clock periods between polls.
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module descriptor_poll_state_regs #(
  parameter int SCRATCH_WORDS = 3
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  // Main control register bits
  input wire logic init_request,
  input wire logic begin_operation_bit,
  input wire logic halt_bit,
  input wire logic suspend_bit,
  // Next receive descriptor fetch
  input wire logic desc_load,
  input wire logic [15:0] rx_descriptor_word1,
  input wire logic [15:0] rx_descriptor_word2,
  // Sequencer status
  output logic poll_trigger,
  output logic init_complete,
  output logic running
);

  poll_regs_pkg::seq_state_type seq_state;
  poll_regs_pkg::seq_state_type next_seq_state;

  poll_regs_pkg::rx_shadow_type rx_shadow;
  poll_regs_pkg::rx_shadow_type next_rx_shadow;
  poll_regs_pkg::rx_shadow_type desc_shadow;
  poll_regs_pkg::rx_shadow_type soft_shadow;

  logic [15:0] interval_register;
  logic [16:0] poll_time_counter;
  wire [31:0] scratch_word [0:SCRATCH_WORDS-1];

  // Access window
  wire access_open = halt_bit | suspend_bit;
  wire write_ok = reg_write & access_open;
  wire read_ok = reg_read & access_open;

  // Address decode
  wire hit_next_rx = (reg_addr == poll_regs_pkg::ADDR_NEXT_RX);
  wire hit_poll = (reg_addr == poll_regs_pkg::ADDR_POLL);
  wire hit_interval = (reg_addr == poll_regs_pkg::ADDR_INTERVAL);
  wire hit_scratch_zero = (reg_addr == poll_regs_pkg::ADDR_SCRATCH_ZERO);
  wire hit_scratch_one = (reg_addr == poll_regs_pkg::ADDR_SCRATCH_ONE);
  wire hit_scratch_two = (reg_addr == poll_regs_pkg::ADDR_SCRATCH_TWO);

  wire write_next_rx = write_ok & hit_next_rx;
  wire write_poll = write_ok & hit_poll;
  wire write_interval = write_ok & hit_interval;

  // Scratch write enables, one per word
  wire [SCRATCH_WORDS-1:0] scratch_hit;
  assign scratch_hit[0] = hit_scratch_zero;
  assign scratch_hit[1] = hit_scratch_one;
  assign scratch_hit[2] = hit_scratch_two;
  wire [SCRATCH_WORDS-1:0] scratch_write = scratch_hit & {SCRATCH_WORDS{write_ok}};

  // Low half of the write word feeds both the interval and the poll counter
  wire [15:0] write_low_half = reg_wdata[poll_regs_pkg::INTERVAL_MSB:0];

  // Start is ignored while halt is still held
  wire start_allowed = begin_operation_bit & ~halt_bit;

  // Sequencer
  always_comb begin
    next_seq_state = seq_state;
    case (seq_state)
      poll_regs_pkg::SEQ_STOPPED: begin
        if (init_request) begin
          next_seq_state = poll_regs_pkg::SEQ_INIT;
        end else if (start_allowed) begin
          next_seq_state = poll_regs_pkg::SEQ_RUNNING;
        end
      end
      poll_regs_pkg::SEQ_INIT: begin
        next_seq_state = poll_regs_pkg::SEQ_STOPPED;
      end
      poll_regs_pkg::SEQ_RUNNING: begin
        if (halt_bit) begin
          next_seq_state = poll_regs_pkg::SEQ_STOPPED;
        end else if (suspend_bit) begin
          next_seq_state = poll_regs_pkg::SEQ_SUSPENDED;
        end
      end
      poll_regs_pkg::SEQ_SUSPENDED: begin
        if (halt_bit) begin
          next_seq_state = poll_regs_pkg::SEQ_STOPPED;
        end else if (!suspend_bit) begin
          next_seq_state = poll_regs_pkg::SEQ_RUNNING;
        end
      end
      default: begin
        next_seq_state = poll_regs_pkg::SEQ_STOPPED;
      end
    endcase
  end

  wire entering_init = (seq_state == poll_regs_pkg::SEQ_INIT);
  wire counting = (seq_state == poll_regs_pkg::SEQ_RUNNING);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seq_state <= poll_regs_pkg::SEQ_STOPPED;
    end else begin
      seq_state <= next_seq_state;
    end
  end

  // Shadow of the next receive descriptor
  assign desc_shadow.status =
    rx_descriptor_word1[poll_regs_pkg::DESC_STATUS_MSB:poll_regs_pkg::DESC_STATUS_LSB];
  assign desc_shadow.count =
    rx_descriptor_word2[poll_regs_pkg::COUNT_MSB:poll_regs_pkg::COUNT_LSB];
  assign soft_shadow.status =
    reg_wdata[poll_regs_pkg::STATUS_MSB:poll_regs_pkg::STATUS_LSB];
  // Reserved bits of the write are dropped on purpose
  assign soft_shadow.count =
    reg_wdata[poll_regs_pkg::COUNT_MSB:poll_regs_pkg::COUNT_LSB];

  // Fetch wins over a software write; software should only write while halted
  assign next_rx_shadow = desc_load ? desc_shadow :
                          write_next_rx ? soft_shadow :
                          rx_shadow;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_shadow <= {poll_regs_pkg::STATUS_RESET, poll_regs_pkg::COUNT_RESET};
    end else begin
      rx_shadow <= next_rx_shadow;
    end
  end

  // Interval register
  wire [15:0] next_interval =
    entering_init ? poll_regs_pkg::INTERVAL_DEFAULT :
    write_interval ? write_low_half :
    interval_register;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      interval_register <= poll_regs_pkg::INTERVAL_DEFAULT;
    end else begin
      interval_register <= next_interval;
    end
  end

  // Reload value: bit 16 implied one, low nibble ignored
  wire [16:0] poll_reload = {1'b1,
    interval_register[poll_regs_pkg::INTERVAL_MSB:poll_regs_pkg::INTERVAL_USED_LSB],
    poll_regs_pkg::INTERVAL_IGNORED_BITS};

  // Poll counter counts half periods up to the 17-bit wrap
  wire [17:0] poll_sum = {1'b0, poll_time_counter}
                         + poll_regs_pkg::HALF_UNITS_PER_CYCLE;
  wire poll_wrap = counting & poll_sum[17];

  // Bit 16 of a written count is implied one, as in the reload
  wire [16:0] poll_write_value = {1'b1, write_low_half};

  wire [16:0] next_poll =
    write_poll ? poll_write_value :
    entering_init ? poll_regs_pkg::POLL_RESET :
    poll_wrap ? poll_reload :
    counting ? poll_sum[16:0] :
    poll_time_counter;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_time_counter <= poll_regs_pkg::POLL_RESET;
    end else begin
      poll_time_counter <= next_poll;
    end
  end

  // Poll request pulse, one cycle per wrap
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      poll_trigger <= 1'b0;
    end else begin
      poll_trigger <= poll_wrap;
    end
  end

  // Scratch words
  genvar g;
  generate
    for (g = 0; g < SCRATCH_WORDS; g = g + 1) begin : gen_scratch
      scratch_slot #(
        .RESET_VALUE(poll_regs_pkg::WORD_RESET)
      ) u_slot (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .write_enable(scratch_write[g]),
        .write_value(reg_wdata),
        .stored_value(scratch_word[g])
      );
    end
  endgenerate

  // Read selection
  wire [31:0] shadow_word = {rx_shadow.status, 12'h000, rx_shadow.count};
  wire [31:0] poll_word = {16'h0000, poll_time_counter[poll_regs_pkg::INTERVAL_MSB:0]};
  wire [31:0] interval_word = {16'h0000, interval_register};

  // Closed window and unmapped addresses read as zero
  logic [31:0] read_value;

  always_comb begin
    read_value = poll_regs_pkg::WORD_RESET;
    if (!read_ok) begin
      read_value = poll_regs_pkg::WORD_RESET;
    end else if (hit_next_rx) begin
      read_value = shadow_word;
    end else if (hit_poll) begin
      read_value = poll_word;
    end else if (hit_interval) begin
      read_value = interval_word;
    end else if (hit_scratch_zero) begin
      read_value = scratch_word[0];
    end else if (hit_scratch_one) begin
      read_value = scratch_word[1];
    end else if (hit_scratch_two) begin
      read_value = scratch_word[2];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= poll_regs_pkg::WORD_RESET;
    end else begin
      reg_rdata <= read_value;
    end
  end

  // Status outputs; a finishing init beats the clear from a held request
  wire next_init_complete = entering_init | (init_complete & ~init_request);
  wire next_running = (next_seq_state == poll_regs_pkg::SEQ_RUNNING);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      init_complete <= 1'b0;
    end else begin
      init_complete <= next_init_complete;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      running <= 1'b0;
    end else begin
      running <= next_running;
    end
  end

endmodule

// One retained word, reused for every scratch slot
module scratch_slot #(
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Write side
  input wire logic write_enable,
  input wire logic [31:0] write_value,
  // Stored word
  output logic [31:0] stored_value
);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stored_value <= RESET_VALUE;
    end else if (write_enable) begin
      stored_value <= write_value;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/poll_regs_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module poll_regs_chk #(
  parameter int SCRATCH_WORDS = 3
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic init_request,
  input wire logic begin_operation_bit,
  input wire logic halt_bit,
  input wire logic suspend_bit,
  input wire logic desc_load,
  input wire logic [15:0] rx_descriptor_word1,
  input wire logic [15:0] rx_descriptor_word2,
  input wire logic poll_trigger,
  input wire logic init_complete,
  input wire logic running
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic win = halt_bit | suspend_bit;
  a_closed_read: assert property (reg_read && !win |=> reg_rdata == 32'h0)
    else $error("closed read not zero");
  a_rsvd_zero: assert property (reg_read && reg_addr == poll_regs_pkg::ADDR_NEXT_RX
    |=> reg_rdata[23:12] == 12'h000) else $error("reserved bits not zero");
  a_shadow_copy: assert property (desc_load ##1 (reg_read && win
    && reg_addr == poll_regs_pkg::ADDR_NEXT_RX) |=> reg_rdata == {$past(rx_descriptor_word1[15:8],
    2), 12'h000, $past(rx_descriptor_word2[11:0], 2)}) else $error("shadow mismatch");
  a_poll_gap: assert property (poll_trigger |=> !poll_trigger [*7])
    else $error("poll pulses too close");
  a_poll_run: assert property (poll_trigger |-> $past(running))
    else $error("poll while not running");
  a_init_done: assert property (init_request && halt_bit && !suspend_bit && !running
    |-> ##[1:3] init_complete) else $error("init never completed");
  a_start_run: assert property (begin_operation_bit && !win && !running && init_complete
    && !init_request |=> running) else $error("start ignored");
  a_scratch_keep: assert property ((reg_write && win
    && reg_addr == poll_regs_pkg::ADDR_SCRATCH_ZERO) ##1 (reg_read && win
    && reg_addr == poll_regs_pkg::ADDR_SCRATCH_ZERO) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("scratch lost");
endmodule
bind descriptor_poll_state_regs poll_regs_chk #(.SCRATCH_WORDS(SCRATCH_WORDS)) u_chk (
  .sys_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .init_request, .begin_operation_bit, .halt_bit, .suspend_bit, .desc_load,
  .rx_descriptor_word1, .rx_descriptor_word2, .poll_trigger, .init_complete, .running);
`default_nettype wire

/* File: testbench/descriptor_poll_state_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module descriptor_poll_state_regs_tb;
  logic sys_clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, init_request = 0;
  logic begin_operation_bit = 0, halt_bit = 1, suspend_bit = 0, desc_load = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  logic [15:0] rx_descriptor_word1 = 16'h0, rx_descriptor_word2 = 16'h0;
  logic poll_trigger, init_complete, running;
  int num_errors = 0, n_compared = 0, n;
  descriptor_poll_state_regs #(.SCRATCH_WORDS(3)) DUT (.sys_clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .init_request, .begin_operation_bit,
    .halt_bit, .suspend_bit, .desc_load, .rx_descriptor_word1, .rx_descriptor_word2,
    .poll_trigger, .init_complete, .running);
  initial forever #12.5 sys_clk = ~sys_clk;
  task end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  // Callers sit just after an edge; writes are always followed by a read
  task wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(e, reg_rdata);
  endtask
  task wp();
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (poll_trigger !== 1'b1 && n < 40000);
    if (n >= 40000) begin
      num_errors++;
      end_of_test();
    end
  endtask
  task do_init();
    init_request <= 1'b1;
    @(posedge sys_clk);
    init_request <= 1'b0;
    #1 chk(32'h0, {31'h0, init_complete});
    n = 0;
    while (init_complete !== 1'b1 && n < 4) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(32'h1, {31'h0, init_complete});
  endtask
  task t_scratch();
    rc(poll_regs_pkg::ADDR_SCRATCH_ZERO, 32'h0);
    rc(8'h31, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(poll_regs_pkg::ADDR_SCRATCH_ZERO + 8'(2 * i), 32'hFFFF_A5C0 + i);
      rc(poll_regs_pkg::ADDR_SCRATCH_ZERO + 8'(2 * i), 32'hFFFF_A5C0 + i);
    end
  endtask
  task t_closed();
    halt_bit <= 1'b0;
    wr(poll_regs_pkg::ADDR_SCRATCH_ONE, 32'h1234_5678);
    rc(poll_regs_pkg::ADDR_SCRATCH_ONE, 32'h0);
    halt_bit <= 1'b1;
    rc(poll_regs_pkg::ADDR_SCRATCH_ONE, 32'hFFFF_A5C1);
    halt_bit <= 1'b0;
    suspend_bit <= 1'b1;
    wr(poll_regs_pkg::ADDR_SCRATCH_TWO, 32'h0BAD_F00D);
    rc(poll_regs_pkg::ADDR_SCRATCH_TWO, 32'h0BAD_F00D);
    suspend_bit <= 1'b0;
    halt_bit <= 1'b1;
  endtask
  task t_shadow();
    rx_descriptor_word1 <= 16'hBEEF;
    rx_descriptor_word2 <= 16'hF123;
    desc_load <= 1'b1;
    @(posedge sys_clk);
    desc_load <= 1'b0;
    rx_descriptor_word1 <= 16'h4110;
    rx_descriptor_word2 <= 16'h0EDC;
    rc(poll_regs_pkg::ADDR_NEXT_RX, 32'hBE00_0123);
    wr(poll_regs_pkg::ADDR_NEXT_RX, 32'hA500_0ABC);
    rc(poll_regs_pkg::ADDR_NEXT_RX, 32'hA500_0ABC);
  endtask
  task t_poll(input logic [31:0] iv, input logic [31:0] per);
    halt_bit <= 1'b1;
    begin_operation_bit <= 1'b0;
    @(posedge sys_clk);
    do_init();
    wr(poll_regs_pkg::ADDR_INTERVAL, iv);
    rc(poll_regs_pkg::ADDR_INTERVAL, iv);
    // Preload the counter near its wrap so the first poll comes quickly
    wr(poll_regs_pkg::ADDR_POLL, 32'h0000_FFF0);
    rc(poll_regs_pkg::ADDR_POLL, 32'h0000_FFF0);
    halt_bit <= 1'b0;
    begin_operation_bit <= 1'b1;
    wp();
    chk(32'h1, {31'h0, running});
    wp();
    chk(per, 32'(n));
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rc(poll_regs_pkg::ADDR_POLL, 32'h0);
    t_scratch();
    t_closed();
    t_shadow();
    // Zero interval is the slow case, 32768 cycles per poll
    t_poll(32'h0000_0000, 32'h0000_8000);
    t_poll(32'h0000_F00F, 32'h0000_0800);
    end_of_test();
  end
endmodule
`default_nettype wire
